// file: dv/dma_event_chk.sv
// port assertions for the dma event flag block
// assumes binding into dma_event_flags, one clock domain
`timescale 1ns/1ps
module dma_event_chk
  import dma_event_pkg::*;
#(
  parameter int CHANNELS = NUM_CHANNELS
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // channel side
  input wire logic [CHANNELS-1:0] complete_event,
  input wire logic [CHANNELS-1:0] error_event,
  input wire logic [CHANNELS-1:0] half_point_irq_enable,
  input wire logic [CHANNELS-1:0] complete_irq_enable,
  input wire logic [CHANNELS-1:0] error_irq_enable,
  input wire logic [CHANNELS-1:0] adc_select,
  input wire logic [CHANNELS-1:0] channel_enable_clear,
  input wire logic [CHANNELS-1:0] periph_req,
  input wire logic adc_req,
  input wire logic [CHANNELS-1:0] channel_request,
  input wire logic [CHANNELS-1:0] channel_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // low only at the very first edge, before any reset has acted
  logic clk_seen = 1'b0;
  always @(posedge sys_clk) clk_seen <= 1'b1;
  wire logic take = hsel && htrans[1] && hready && hreadyout;
  wire logic [CHANNELS-1:0] tc_on = complete_event & complete_irq_enable;
  wire logic [CHANNELS-1:0] en_any =
    half_point_irq_enable | complete_irq_enable | error_irq_enable;
  sequence narrow_req;
    take && hsize != HSIZE_WORD;
  endsequence
  sequence err_two;
    !hreadyout && hresp ##1 hreadyout && hresp ##1 !hresp;
  endsequence
  req_mux_a: assert property ($past(reset_n, 3) && $past(reset_n, 2) && $past(reset_n) |->
      channel_request ==
      (($past(adc_select) & {CHANNELS{$past(adc_req)}}) | (~$past(adc_select) & $past(periph_req))))
    else $error("request select wrong");
  irq_set_a: assert property (|tc_on |=>
      (channel_irq & $past(tc_on)) == $past(tc_on))
    else $error("enabled event gave no irq");
  irq_mask_a: assert property ((channel_irq & ~en_any & ~$past(en_any)) == '0)
    else $error("irq without enable");
  err_disable_a: assert property ($past(reset_n, 3) && $past(reset_n, 2) && $past(reset_n) |->
      channel_enable_clear == $past(error_event))
    else $error("enable clear pulse wrong");
  word_ok_a: assert property (take && hsize == HSIZE_WORD |=>
      hreadyout && hresp == HRESP_OKAY)
    else $error("word access not okay");
  narrow_err_a: assert property (narrow_req |=> err_two)
    else $error("narrow access not refused");
  zero_read_a: assert property (take && (hwrite || haddr[7:0] != STATUS_OFFSET) |=>
      hrdata == READ_ZERO)
    else $error("read data not zero");
  reset_out_a: assert property (disable iff (1'b0) clk_seen && !reset_n |->
      hreadyout && hresp == HRESP_OKAY && hrdata == READ_ZERO && channel_irq == '0)
    else $error("outputs not idle in reset");
endmodule
bind dma_event_flags dma_event_chk #(.CHANNELS(CHANNELS)) i_dma_event_chk (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .hsel(hsel),
  .haddr(haddr),
  .htrans(htrans),
  .hwrite(hwrite),
  .hsize(hsize),
  .hready(hready),
  .hrdata(hrdata),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .complete_event(complete_event),
  .error_event(error_event),
  .half_point_irq_enable(half_point_irq_enable),
  .complete_irq_enable(complete_irq_enable),
  .error_irq_enable(error_irq_enable),
  .adc_select(adc_select),
  .channel_enable_clear(channel_enable_clear),
  .periph_req(periph_req),
  .adc_req(adc_req),
  .channel_request(channel_request),
  .channel_irq(channel_irq)
);

// file: dv/req_source.sv
// peripheral and converter request sources for the dma selector
// assumes one sys_clk shared with the block under test
`timescale 1ns/1ps
module req_source (
  // clock
  input wire logic sys_clk,
  // requests
  output logic [7:0] periph_req,
  output logic adc_req
);
  logic [7:0] count_reg = 8'h00;
  always_ff @(posedge sys_clk) begin
    count_reg <= count_reg + 8'h01;
  end
  // eight lines, new pattern every cycle except when count_reg steps to 8'h80 or 8'h00
  assign periph_req = count_reg ^ {count_reg[0], count_reg[7:1]};
  assign adc_req = count_reg[1];
endmodule

// file: dv/testbench.sv
// self-checking bench for the dma event flag block
// assumes req_source drives the request lines
`timescale 1ns/1ps
module testbench
  import dma_event_pkg::*;
;
  typedef struct {int ch; int k; logic [31:0] exp;} row_t;
  row_t rows [10] = '{'{0, 0, 32'h0000_0005}, '{0, 1, 32'h0000_0003}, '{0, 2, 32'h0000_0009},
    '{1, 0, 32'h0000_0050}, '{1, 1, 32'h0000_0030}, '{1, 2, 32'h0000_0090},
    '{2, 0, 32'h0000_0500}, '{2, 1, 32'h0000_0300}, '{2, 2, 32'h0000_0900},
    '{7, 2, 32'h9000_0000}};
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata, rd;
  logic hready, hreadyout, hresp, adc_req, rsp;
  logic [7:0] evt [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] hie = 8'h05, cie = 8'h55, eie = 8'h01, asel = 8'h0F;
  logic [7:0] periph_req, channel_request, channel_irq;
  int fail_count = 0;
  int comparisons = 0;
  assign hready = hreadyout;
  initial forever #4 sys_clk = ~sys_clk;
  dma_event_flags i_dma_event_flags (.sys_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .half_point_event(evt[0]),
    .complete_event(evt[1]), .error_event(evt[2]), .half_point_irq_enable(hie),
    .complete_irq_enable(cie), .error_irq_enable(eie), .adc_select(asel),
    .channel_enable_clear(), .periph_req, .adc_req, .channel_request, .channel_irq);
  req_source i_req_source (.sys_clk, .periph_req, .adc_req);
  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    chk32(n, {24'h00_0000, e}, {24'h00_0000, g});
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // one bus transfer, event pulse k driven in its first data cycle
  task automatic bus(input logic [7:0] a, input logic w, input logic [2:0] sz,
      input logic [31:0] wd, input int k, input logic [7:0] ev);
    int n;
    n = 0;
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= DMA_BASE_ADDR | {24'h00_0000, a};
    hwrite <= w;
    hsize <= sz;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!hreadyout && n < 16);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    evt[k] <= ev;
    @(posedge sys_clk);
    evt[k] <= 8'h00;
    while (!hreadyout && n < 16) begin
      @(posedge sys_clk);
      n++;
    end
    rd = hrdata;
    rsp = hresp;
    if (n >= 16) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic rd_status();
    bus(STATUS_OFFSET, 1'b0, HSIZE_WORD, 32'h0000_0000, 0, 8'h00);
  endtask
  task automatic wr_clear(input logic [31:0] d, input int k, input logic [7:0] ev);
    bus(CLEAR_OFFSET, 1'b1, HSIZE_WORD, d, k, ev);
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    foreach (rows[i]) begin
      bus(8'h10, 1'b0, HSIZE_WORD, 32'h0000_0000, rows[i].k, 8'h01 << rows[i].ch);
      rd_status();
      chk32("status", rows[i].exp, rd);
      wr_clear(rows[i].exp & ~(32'h0000_0001 << 4 * rows[i].ch), 0, 8'h00);
      rd_status();
      chk32("status", 32'h0000_0000, rd);
    end
    asel <= 8'hF0;
    wr_clear(32'h0000_0000, 0, 8'h01);
    wr_clear(32'h0000_0000, 1, 8'h01);
    rd_status();
    chk32("status", 32'h0000_0007, rd);
    chk8("irq", 8'h01, channel_irq);
    wr_clear(32'h0000_0006, 0, 8'h01);
    rd_status();
    chk32("status", 32'h0000_0005, rd);
    bus(CLEAR_OFFSET, 1'b1, 3'h0, 32'hFFFF_FFFF, 0, 8'h00);
    chk8("hresp", 8'h01, {7'h00, rsp});
    repeat (2) @(posedge sys_clk);
    bus(STATUS_OFFSET, 1'b1, HSIZE_WORD, 32'hFFFF_FFFF, 0, 8'h00);
    chk8("hresp", 8'h00, {7'h00, rsp});
    rd_status();
    chk32("status", 32'h0000_0005, rd);
    wr_clear(32'h0000_0004, 2, 8'h02);
    rd_status();
    chk32("status", 32'h0000_0090, rd);
    chk8("irq", 8'h00, channel_irq);
    wr_clear(32'h0000_0000, 0, 8'h01);
    rd_status();
    chk32("status", 32'h0000_0095, rd);
    chk8("irq", 8'h01, channel_irq);
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd_status();
    chk32("status", STATUS_RESET, rd);
    chk8("irq", 8'h00, channel_irq);
    print_verdict();
  end
endmodule

// file: hw/chan_event_unit.sv
// one channel: sticky event flags, gated interrupt, request select
// assumes events and requests come from logic on sys_clk
`timescale 1ns/1ps
module chan_event_unit
  import dma_event_pkg::*;
(
  // clock and synchronised reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // channel link to the register block
  chan_if.unit port
);

  typedef struct packed {
    logic complete;
    logic half;
    logic error;
    logic any_event;
    logic irq;
    logic disable_pulse;
    logic request;
  } unit_state_t;

  unit_state_t state_reg;
  unit_state_t state_next;

  logic clr_all;

  always_comb begin
    state_next = state_reg;
    clr_all = port.clear_bits[FLAG_GLOBAL];
    // set wins over clear; zero bits leave flags alone unless the global bit is one
    state_next.complete = (state_reg.complete & ~(clr_all | port.clear_bits[FLAG_COMPLETE]))
      | port.complete_event;
    state_next.half = (state_reg.half & ~(clr_all | port.clear_bits[FLAG_HALF]))
      | port.half_point_event;
    state_next.error = (state_reg.error & ~(clr_all | port.clear_bits[FLAG_ERROR]))
      | port.error_event;
    state_next.any_event = state_next.complete | state_next.half | state_next.error;
    state_next.irq = (state_next.complete & port.complete_irq_enable)
      | (state_next.half & port.half_point_irq_enable)
      | (state_next.error & port.error_irq_enable);
    // drop the channel enable on a transfer error
    state_next.disable_pulse = port.error_event;
    state_next.request = port.adc_select ? port.adc_req : port.periph_req;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign port.flags = {state_reg.error, state_reg.half, state_reg.complete, state_reg.any_event};
  assign port.irq = state_reg.irq;
  assign port.disable_pulse = state_reg.disable_pulse;
  assign port.request = state_reg.request;

endmodule

// file: hw/dma_event_flags.sv
// dma event flags, clear register and per-channel request selector
// assumes a 32-bit ahb-lite register port; events come from the
// transfer engine and requests from peripherals, all on sys_clk
//
// Behaviour
// - three events per channel: half, complete, error
// - interrupt only when flag and its enable set
// - eight peripheral requests muxed with converter request
// - per-channel select: peripheral or converter request
// - base 0xA0000000, status 0x00, clear 0x04
// - status read-only, clear write-only, reset zero
// - channel 0 flags at bits 0 to 3
// - channel 1 flags at bits 4 to 7
// - channel 2 flags at bits 8 to 11
// - hardware sets flags, writing one clears them
// - global flag is or of channel flags
// - error bit 11; four bits per channel onward
// - error clears channel enable; interrupt if enabled
`timescale 1ns/1ps
module dma_event_flags
  import dma_event_pkg::*;
#(
  parameter int CHANNELS = NUM_CHANNELS
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register port
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // channel events from the transfer engine
  input wire logic [CHANNELS-1:0] half_point_event,
  input wire logic [CHANNELS-1:0] complete_event,
  input wire logic [CHANNELS-1:0] error_event,
  // channel configuration bits
  input wire logic [CHANNELS-1:0] half_point_irq_enable,
  input wire logic [CHANNELS-1:0] complete_irq_enable,
  input wire logic [CHANNELS-1:0] error_irq_enable,
  input wire logic [CHANNELS-1:0] adc_select,
  output logic [CHANNELS-1:0] channel_enable_clear,
  // requests
  input wire logic [CHANNELS-1:0] periph_req,
  input wire logic adc_req,
  output logic [CHANNELS-1:0] channel_request,
  // interrupts
  output logic [CHANNELS-1:0] channel_irq
);

  typedef struct packed {
    bus_state_t bus;
    logic [31:0] rdata;
    logic hreadyout;
    logic hresp;
    logic clear_write;
  } bus_regs_t;

  bus_regs_t state_reg;
  bus_regs_t state_next;

  logic [1:0] rst_sync_reg;
  logic rst_n;

  logic [31:0] status_word;
  logic [31:0] clear_word;
  logic accept;
  logic [7:0] offset;

  // reset release through two flops
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // write data lands in the data phase after the address phase
  assign clear_word = state_reg.clear_write ? hwdata : CLEAR_RESET;

  // per-channel units and status packing
  genvar ch;
  generate
    for (ch = 0; ch < 8; ch++) begin : g_chan
      if (ch < CHANNELS) begin : g_used
        chan_if cif();

        assign cif.half_point_event = half_point_event[ch];
        assign cif.complete_event = complete_event[ch];
        assign cif.error_event = error_event[ch];
        assign cif.clear_bits = clear_word[ch*BITS_PER_CHANNEL +: BITS_PER_CHANNEL];
        assign cif.half_point_irq_enable = half_point_irq_enable[ch];
        assign cif.complete_irq_enable = complete_irq_enable[ch];
        assign cif.error_irq_enable = error_irq_enable[ch];
        assign cif.adc_select = adc_select[ch];
        assign cif.periph_req = periph_req[ch];
        assign cif.adc_req = adc_req;

        chan_event_unit u_unit (
          .sys_clk(sys_clk),
          .rst_n(rst_n),
          .port(cif.unit)
        );

        // nibble per channel: global, complete, half, error
        assign status_word[ch*BITS_PER_CHANNEL +: BITS_PER_CHANNEL] = cif.flags;
        assign channel_irq[ch] = cif.irq;
        assign channel_enable_clear[ch] = cif.disable_pulse;
        assign channel_request[ch] = cif.request;
      end else begin : g_unused
        assign status_word[ch*BITS_PER_CHANNEL +: BITS_PER_CHANNEL] = 4'h0;
      end
    end
  endgenerate

  assign accept = hsel & htrans[HTRANS_ACTIVE_BIT] & hready;
  assign offset = haddr[7:0];

  always_comb begin
    state_next = state_reg;
    state_next.clear_write = 1'b0;
    state_next.rdata = READ_ZERO;
    unique case (state_reg.bus)
      BUS_IDLE: begin
        state_next.hreadyout = 1'b1;
        state_next.hresp = HRESP_OKAY;
      end
      BUS_ERR_FIRST: begin
        // second error cycle completes the transfer
        state_next.bus = BUS_ERR_LAST;
        state_next.hreadyout = 1'b1;
        state_next.hresp = HRESP_ERROR;
      end
      BUS_ERR_LAST: begin
        state_next.bus = BUS_IDLE;
        state_next.hreadyout = 1'b1;
        state_next.hresp = HRESP_OKAY;
      end
      default: begin
        state_next.bus = BUS_IDLE;
        state_next.hreadyout = 1'b1;
        state_next.hresp = HRESP_OKAY;
      end
    endcase
    // address phase decode, not during the first error cycle
    if (accept && state_reg.bus != BUS_ERR_FIRST) begin
      if (hsize != HSIZE_WORD) begin
        // any size other than word: two-cycle error answer
        state_next.bus = BUS_ERR_FIRST;
        state_next.hreadyout = 1'b0;
        state_next.hresp = HRESP_ERROR;
      end else begin
        state_next.bus = BUS_IDLE;
        state_next.hreadyout = 1'b1;
        state_next.hresp = HRESP_OKAY;
        // clear register only takes writes; status only reads
        state_next.clear_write = hwrite && (offset == CLEAR_OFFSET);
        if (!hwrite && offset == STATUS_OFFSET) begin
          state_next.rdata = status_word;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg.bus <= BUS_IDLE;
      state_reg.rdata <= STATUS_RESET;
      state_reg.hreadyout <= 1'b1;
      state_reg.hresp <= HRESP_OKAY;
      state_reg.clear_write <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign hrdata = state_reg.rdata;
  assign hreadyout = state_reg.hreadyout;
  assign hresp = state_reg.hresp;

endmodule

// file: shared/chan_if.sv
// signals between the register block and one channel event unit
// assumes both ends share sys_clk
`timescale 1ns/1ps
interface chan_if;
  logic half_point_event;
  logic complete_event;
  logic error_event;
  logic [3:0] clear_bits;
  logic half_point_irq_enable;
  logic complete_irq_enable;
  logic error_irq_enable;
  logic adc_select;
  logic periph_req;
  logic adc_req;
  logic [3:0] flags;
  logic irq;
  logic disable_pulse;
  logic request;

  modport top (
    output half_point_event, complete_event, error_event, clear_bits,
    output half_point_irq_enable, complete_irq_enable, error_irq_enable,
    output adc_select, periph_req, adc_req,
    input flags, irq, disable_pulse, request
  );

  modport unit (
    input half_point_event, complete_event, error_event, clear_bits,
    input half_point_irq_enable, complete_irq_enable, error_irq_enable,
    input adc_select, periph_req, adc_req,
    output flags, irq, disable_pulse, request
  );
endinterface

// file: shared/dma_event_pkg.sv
// constants for the dma event flag and request selector block
// assumes a 32-bit ahb-lite style register port and one system clock
package dma_event_pkg;

  // channel count and register map
  localparam int NUM_CHANNELS = 8;
  localparam int BITS_PER_CHANNEL = 4;
  localparam logic [31:0] DMA_BASE_ADDR = 32'hA000_0000;
  localparam logic [7:0] STATUS_OFFSET = 8'h00;
  localparam logic [7:0] CLEAR_OFFSET = 8'h04;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  localparam logic [31:0] CLEAR_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // field positions inside one channel nibble
  localparam int FLAG_GLOBAL = 0;
  localparam int FLAG_COMPLETE = 1;
  localparam int FLAG_HALF = 2;
  localparam int FLAG_ERROR = 3;

  // bus encodings
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int HTRANS_ACTIVE_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;
  localparam logic HRESP_ERROR = 1'b1;

  // bus response states
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_ERR_FIRST = 3'b010,
    BUS_ERR_LAST = 3'b100
  } bus_state_t;

endpackage
